// ==== shared/sac_params.svh ====
// Purpose: timing counts and constants for the serial converter readout
// Assumes: mclk at 10 MHz
// Notes: counts derived from times in ns
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
`define SAC_CLK_PERIOD_NS   100
`define SAC_RES_BITS        16
`define SAC_START_LOW_NS    50
`define SAC_START_LOW_CYC   (((`SAC_START_LOW_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS) < 1 ? 1 : \
                             ((`SAC_START_LOW_NS + `SAC_CLK_PERIOD_NS - 1) / `SAC_CLK_PERIOD_NS))
`define SAC_EDGE_SEP_NS     10
`define SAC_CONV_CYC        40
`define SAC_BITCLK_HALF     2
`define SAC_FIFO_DEPTH      8
`define SAC_MSB_SIGN        16'h8000
`endif

// ==== shared/sac_pkg.sv ====
// Purpose: types for the serial converter readout
// Assumes: nothing
// Notes: result word carries the chain level captured at start
package sac_pkg;
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_CONV,
    SAC_DONE
  } sac_conv_e;
  typedef struct packed {
    logic [15:0] data;
    logic        chain;
  } sac_word_s;
endpackage

// ==== hw/sac_fifo.sv ====
// Purpose: result fifo between converter and serial link
// Assumes: single clock, valid/ready both sides
// Notes: full/empty from counters
`timescale 1ns/1ps
module sac_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop) rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // sac_fifo

// ==== hw/sac_sync.sv ====
// Purpose: two-flop synchroniser for a bundle of levels
// Assumes: destination clock clk
// Notes: first stage read only by second
`timescale 1ns/1ps
module sac_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         clk,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk) begin
    meta <= d;
    q    <= meta;
  end
endmodule // sac_sync

// ==== hw/sac_top.sv ====
// Purpose: conversion control and serial readout of a 16-bit converter
// Assumes: host strobes async to mclk; external bit clock is its own domain
// Notes: analog core modelled by sample_data input and a fixed conversion time
// How it works
// - format select low gives two's complement, high gives straight binary.
// - internal clock mode sends 16 bit clock pulses after each start.
// - external mode: host drives bit clock, data changes with it.
// - external mode: read start gives one-period frame marker pulse.
// - internal mode: clock pin is output, data stable over the rising edge, changes with the falling edge.
// - result held in shift register, sent most significant bit first.
// - between conversions data output holds chain level captured at start.
// - external mode: previous result readable during conversion or after.
// - chain level appears after 16 periods without marker, 17 with.
// - chip select low: read/convert falling starts conversion.
// - chip select low: read/convert rising enables transmission in external mode.
// - read/convert low: chip select falling starts conversion.
// - read/convert high: chip select falling starts readout in external mode.
// - busy low on start, high after result latched.
// - power down refuses starts and keeps previous result.
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_top #(
  parameter int CONV_CYC = `SAC_CONV_CYC,
  parameter int NBITS    = `SAC_RES_BITS
) (
  // system clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // host strobes (pins)
  input  wire logic             cs_b,
  input  wire logic             read_convert,
  input  wire logic             clock_source_select,
  input  wire logic             output_format_select,
  input  wire logic             power_down_input,
  input  wire logic             chain_in,
  // converter core sample
  input  wire logic [NBITS-1:0] sample_data,
  // external bit clock domain
  input  wire logic             ext_bit_clk,
  // serial link outputs
  output logic                  serial_bit_clock_o,
  output logic                  serial_bit_clock_oe,
  output logic                  serial_data,
  output logic                  frame_marker,
  output logic                  busy,
  output sac_pkg::sac_word_s    last_result
);
  import sac_pkg::*;

  // synchronised pins
  logic [5:0] pin_s;
  sac_sync #(.W(6)) u_pin_sync (
    .clk (mclk),
    .d   ({cs_b, read_convert, clock_source_select, output_format_select, power_down_input, chain_in}),
    .q   (pin_s)
  );
  wire cs_s  = pin_s[5];
  wire rc_s  = pin_s[4];
  wire ext_s = pin_s[3];
  wire fmt_s = pin_s[2];
  wire pd_s  = pin_s[1];
  wire tag_s = pin_s[0];

  logic cs_d;
  logic rc_d;
  always_ff @(posedge mclk) begin
    cs_d <= cs_s;
    rc_d <= rc_s;
  end

  // strobe decode
  wire rc_fall   = rc_d && !rc_s;
  wire rc_rise   = !rc_d && rc_s;
  wire cs_fall   = cs_d && !cs_s;
  wire start_req = (rc_fall && !cs_s) || (cs_fall && !rc_s);
  wire read_req  = (rc_rise && !cs_s) || (cs_fall && rc_s);

  // conversion sequencer
  sac_conv_e          state;
  sac_conv_e          next_state;
  logic [15:0]        conv_cnt;
  logic [NBITS-1:0]   held_sample;
  logic               held_tag;
  wire                conv_go   = start_req && !pd_s && (state == SAC_IDLE);
  wire                conv_end  = (state == SAC_CONV) && (conv_cnt == 16'(CONV_CYC - 1));
  wire [NBITS-1:0]    fmt_word  = fmt_s ? (held_sample ^ NBITS'(`SAC_MSB_SIGN)) : held_sample;

  always_comb begin
    next_state = state;
    unique case (state)
      SAC_IDLE: if (conv_go) next_state = SAC_CONV;
      SAC_CONV: if (conv_end) next_state = SAC_DONE;
      SAC_DONE: next_state = SAC_IDLE;
    endcase
  end

  // fifo handshake
  sac_word_s fifo_in;
  sac_word_s fifo_out;
  logic      fifo_in_ready;
  logic      fifo_out_valid;
  logic      fifo_pop;
  assign fifo_in = '{data: fmt_word, chain: held_tag};

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state       <= SAC_IDLE;
      conv_cnt    <= '0;
      held_sample <= '0;
      held_tag    <= 1'b0;
      busy        <= 1'b1;
    end else begin
      state <= (state == SAC_DONE && !fifo_in_ready) ? SAC_DONE : next_state;
      conv_cnt <= (state == SAC_CONV) ? conv_cnt + 16'h0001 : 16'h0000;
      if (conv_go) begin
        held_sample <= sample_data;
        held_tag    <= tag_s;
        busy        <= 1'b0;
      end else if (fifo_pop) begin
        // busy rises with the edge that loads last_result
        busy <= 1'b1;
      end
    end
  end

  sac_fifo #(.WIDTH($bits(sac_word_s)), .DEPTH(`SAC_FIFO_DEPTH)) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (state == SAC_DONE),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out)
  );

  // latest result, kept through power down
  assign fifo_pop = fifo_out_valid;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      last_result <= '0;
    end else if (fifo_pop) begin
      last_result <= fifo_out;
    end
  end

  // internal clock shifter
  logic [NBITS-1:0] int_shift;
  logic [4:0]       int_bits;
  logic [1:0]       int_div;
  logic             int_clk;
  logic             int_go;
  assign int_go = !ext_s && start_req && !pd_s;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      int_shift <= '0;
      int_bits  <= '0;
      int_div   <= '0;
      int_clk   <= 1'b0;
    end else if (int_go && int_bits == 5'h00) begin
      int_shift <= last_result.data;
      int_bits  <= 5'(NBITS);
      int_div   <= '0;
      int_clk   <= 1'b0;
    end else if (int_bits != 5'h00) begin
      int_div <= int_div + 2'h1;
      if (int_div == 2'(`SAC_BITCLK_HALF - 1)) begin
        int_clk <= 1'b1;
      end else if (int_div == 2'(2 * `SAC_BITCLK_HALF - 1)) begin
        int_clk   <= 1'b0;
        int_shift <= {int_shift[NBITS-2:0], 1'b0};
        int_bits  <= int_bits - 5'h01;
      end
    end
  end

  // read request toggle into external domain
  logic rd_tog;
  always_ff @(posedge mclk) begin
    if (!rst_b) rd_tog <= 1'b0;
    else if (read_req && ext_s) rd_tog <= !rd_tog;
  end

  // external clock domain
  logic [2:0]       ext_in;
  logic             rd_tog_x;
  logic             rd_tog_seen;
  logic [NBITS-1:0] ext_shift;
  logic [4:0]       ext_cnt;
  logic             ext_busy;
  logic             ext_mark;
  logic             ext_tag;
  sac_sync #(.W(3)) u_ext_sync (
    .clk (ext_bit_clk),
    .d   ({rd_tog, chain_in, ext_s}),
    .q   (ext_in)
  );
  assign rd_tog_x = ext_in[2];
  wire   ext_start = rd_tog_x != rd_tog_seen;
  always_ff @(posedge ext_bit_clk) begin
    rd_tog_seen <= rd_tog_x;
    ext_tag     <= ext_in[1];
    if (ext_start) begin
      ext_shift <= last_result.data;
      ext_cnt   <= 5'(NBITS + 1);
      ext_busy  <= 1'b1;
      ext_mark  <= 1'b1;
    end else if (!ext_in[0]) begin
      // internal bursts clock this domain and clear it
      ext_busy <= 1'b0;
      ext_mark <= 1'b0;
    end else if (ext_busy) begin
      ext_mark <= 1'b0;
      if (!ext_mark) ext_shift <= {ext_shift[NBITS-2:0], ext_tag};
      ext_cnt  <= ext_cnt - 5'h01;
      ext_busy <= ext_cnt != 5'h01;
    end
  end

  // output select
  wire ext_bit = ext_busy ? ext_shift[NBITS-1] : last_result.chain;
  wire int_bit = (int_bits != 5'h00) ? int_shift[NBITS-1] : last_result.chain;
  logic ext_bit_s;
  logic ext_mark_s;
  sac_sync #(.W(2)) u_back_sync (
    .clk (mclk),
    .d   ({ext_bit, ext_mark}),
    .q   ({ext_bit_s, ext_mark_s})
  );
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      serial_bit_clock_o  <= 1'b0;
      serial_bit_clock_oe <= 1'b0;
      serial_data         <= 1'b0;
      frame_marker        <= 1'b0;
    end else begin
      serial_bit_clock_o  <= int_clk;
      serial_bit_clock_oe <= !ext_s;
      serial_data         <= ext_s ? ext_bit_s : int_bit;
      frame_marker        <= ext_s && ext_mark_s;
    end
  end
endmodule // sac_top

// ==== verification/sac_top_chk.sv ====
// Purpose: port checks on sac_top
// Assumes: strobes held 3+ mclk
// Notes: bound at foot
`timescale 1ns/1ps
module sac_top_chk import sac_pkg::*; #(
  parameter int CONV_CYC = 40
) (
  // clock and reset
  input wire logic               mclk,
  input wire logic               rst_b,
  // pins
  input wire logic               cs_b,
  input wire logic               read_convert,
  input wire logic               clock_source_select,
  input wire logic               power_down_input,
  input wire logic               serial_bit_clock_o,
  input wire logic               serial_bit_clock_oe,
  input wire logic               serial_data,
  input wire logic               frame_marker,
  input wire logic               busy,
  input wire sac_pkg::sac_word_s last_result
);
  logic [7:0] low_cnt;
  always_ff @(posedge mclk) begin
    if (!rst_b || busy)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_hi2;
    serial_bit_clock_o [*2];
  endsequence
  sequence s_pd_idle;
    power_down_input [*4] ##0 busy;
  endsequence
  a_busy_reset: assert property (disable iff (1'b0) !rst_b |=> busy)
    else $error("busy low after reset");
  a_busy_span: assert property ($rose(busy) |-> low_cnt >= CONV_CYC && low_cnt <= CONV_CYC + 4)
    else $error("bad conversion length");
  a_start_cause: assert property ($fell(busy) |-> !$past(cs_b) && !$past(read_convert))
    else $error("busy fell unprompted");
  a_pd_refuse: assert property (s_pd_idle |=> busy && $stable(last_result))
    else $error("start in power down");
  a_frame_len: assert property ($rose(frame_marker) |-> ##[1:3] !frame_marker)
    else $error("marker too long");
  a_oe_mode: assert property (($stable(clock_source_select) && $past(rst_b)) [*5] |->
                              serial_bit_clock_oe != clock_source_select)
    else $error("bit clock direction");
  a_int_pulse: assert property ($rose(serial_bit_clock_o) |-> s_hi2 ##1 !serial_bit_clock_o)
    else $error("bit clock width");
  a_int_hold: assert property (serial_bit_clock_oe && serial_bit_clock_o |-> $stable(serial_data))
    else $error("data moved mid bit");
endmodule // sac_top_chk
bind sac_top sac_top_chk #(.CONV_CYC(CONV_CYC)) sac_top_chk_i (
  .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .read_convert(read_convert),
  .clock_source_select(clock_source_select), .power_down_input(power_down_input),
  .serial_bit_clock_o(serial_bit_clock_o), .serial_bit_clock_oe(serial_bit_clock_oe),
  .serial_data(serial_data), .frame_marker(frame_marker), .busy(busy), .last_result(last_result)
);

// ==== verification/sac_host_model.sv ====
// Purpose: host side, link clock and capture
// Assumes: clock runs only while run high
// Notes: capture on falling edge
`timescale 1ns/1ps
module sac_host_model (
  // bench control
  input  wire logic        run,
  // link
  output logic             ext_bit_clk,
  input  wire logic        serial_data,
  output logic      [63:0] rx
);
  initial begin
    ext_bit_clk = 1'b0;
    rx = 64'h0;
    forever begin
      #37;
      if (run) begin
        ext_bit_clk = 1'b1;
        #62.5;
        ext_bit_clk = 1'b0;
        rx = {rx[62:0], serial_data};
        #25.5;
      end
    end
  end
endmodule // sac_host_model

// ==== verification/tb_top.sv ====
// Purpose: self-checking bench for sac_top
// Assumes: CONV_CYC cut to 16, long enough for a read to start mid conversion
// Notes: xorshift stimulus seeded 54
`timescale 1ns/1ps
`include "sac_params.svh"
module tb_top;
  import sac_pkg::*;
  logic        mclk, rst_b, cs_b, read_convert, ccs, fmt, pd, chain_in, ext_run;
  logic        host_clk, bclk, sbc_o, sbc_oe, sdata, frame, busy, frame_seen, low_seen, prev_o, pf;
  logic [15:0] sample, shot;
  logic [31:0] seed;
  logic [63:0] rx;
  sac_word_s   res, exp_w;
  int          fails, n_compared, pulses;
  assign bclk = sbc_oe ? sbc_o : host_clk;
  sac_top #(.CONV_CYC(16)) sac_top_i (
    .mclk(mclk), .rst_b(rst_b), .cs_b(cs_b), .read_convert(read_convert), .clock_source_select(ccs),
    .output_format_select(fmt), .power_down_input(pd), .chain_in(chain_in), .sample_data(sample),
    .ext_bit_clk(bclk), .serial_bit_clock_o(sbc_o), .serial_bit_clock_oe(sbc_oe), .serial_data(sdata),
    .frame_marker(frame), .busy(busy), .last_result(res)
  );
  sac_host_model sac_host_model_i (.run(ext_run), .ext_bit_clk(host_clk), .serial_data(sdata), .rx(rx));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic found(input logic [63:0] r, input logic [16:0] p);
    for (int i = 0; i < 48; i++)
      if (r[i +: 17] === p)
        return 1'b1;
    return 1'b0;
  endfunction
  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] expv);
    n_compared++;
    if (seen !== expv) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // one start strobe, then checks by mode
  task automatic conv(input logic [15:0] s, input logic f, input logic p, input logic order);
    logic [15:0] old;
    old = exp_w.data;
    sample = s;
    chain_in = seed[16];
    fmt = f;
    pd = p;
    pulses = 0;
    frame_seen = 1'b0;
    low_seen = 1'b0;
    if (order)
      cs_b = 1'b0;
    else
      read_convert = 1'b0;
    tick(1);
    cs_b = 1'b0;
    read_convert = 1'b0;
    tick(6);
    read_convert = 1'b1;
    tick(3);
    cs_b = 1'b1;
    for (int k = 0; k < 40 && busy !== 1'b1; k++)
      tick(1);
    if (!p)
      exp_w = {(f ? s ^ `SAC_MSB_SIGN : s), chain_in};
    chk("busy low", low_seen, !p);
    chk("result", res, exp_w);
    tick(ccs ? 30 : 70);
    if (ccs) begin
      chk("marker", frame_seen, 1'b1);
      chk("read old", found(rx, {old, chain_in}), 1'b1);
    end else begin
      chk("pulses", pulses, p ? 0 : 16);
      if (!p && f === pf)
        chk("burst", shot, old);
      if (!p)
        chk("idle", sdata, chain_in);
    end
    if (!p)
      pf = f;
  endtask
  task automatic read_new();
    frame_seen = 1'b0;
    cs_b = 1'b0;
    tick(4);
    cs_b = 1'b1;
    tick(36);
    chk("marker", frame_seen, 1'b1);
    chk("read new", found(rx, exp_w), 1'b1);
  endtask
  always @(posedge mclk) begin
    if (frame === 1'b1)
      frame_seen <= 1'b1;
    if (busy === 1'b0)
      low_seen <= 1'b1;
    if (sbc_oe && sbc_o && !prev_o) begin
      pulses <= pulses + 1;
      shot <= {shot[14:0], sdata};
    end
    prev_o <= sbc_o;
  end
  initial begin
    rst_b = 1'b0;
    cs_b = 1'b1;
    read_convert = 1'b1;
    ccs = 1'b0;
    fmt = 1'b0;
    pd = 1'b0;
    chain_in = 1'b0;
    sample = 16'h0000;
    ext_run = 1'b0;
    seed = 32'h0000_0036;
    exp_w = '0;
    pf = 1'bx;
    fails = 0;
    n_compared = 0;
    tick(2);
    rst_b = 1'b1;
    chk("busy reset", busy, 1'b1);
    tick(3);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      conv(i == 0 ? 16'h8000 : i == 1 ? 16'h7FFF : seed[15:0], i[2], i == 5, i[0]);
    end
    ccs = 1'b1;
    ext_run = 1'b1;
    tick(6);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      conv(seed[15:0], i[0], 1'b0, 1'b0);
      read_new();
    end
    print_verdict();
  end
  // about four and a half times the expected run
  initial begin
    #500000;
    fails++;
    print_verdict();
  end
endmodule // tb_top
